// ==== lss_defs.svh ====
`ifndef LSS_DEFS_SVH
`define LSS_DEFS_SVH
// Register offsets
`define LSS_A_STATUS 3'h0
`define LSS_A_DATA 3'h1
`define LSS_A_BAUD 3'h2
`define LSS_A_EXT 3'h3
`define LSS_A_CR1 3'h4
`define LSS_A_CR2 3'h5
`define LSS_A_CR3 3'h6
// Reset values
`define LSS_STATUS_RST 8'hc0
`define LSS_CR_RST 8'h00
// Field positions
`define LSS_B_PAR_CHK 2
`define LSS_B_PAR_IRQ 0
`define LSS_B_RX_IRQ 5
`define LSS_B_MUTE 1
`define LSS_B_BRK 0
`define LSS_B_DIV_UPD 7
`define LSS_B_LIN_EN 6
`define LSS_B_SLAVE 5
`define LSS_B_ASYNC 4
`define LSS_B_HDR_MTH 3
`define LSS_B_HDR_IRQ 2
`define LSS_B_HDR_DET 1
`define LSS_B_SYNC_ST 0
// Timing in bit times and oversampling
`define LSS_OVS 16
`define LSS_BRK_BITS 11
`define LSS_MBRK_BITS 13
`define LSS_PBRK_BITS 10
`define LSS_HDR_MAX_BITS 57
`define LSS_SYNC_BYTE 8'h55
`endif

// ==== lss_pkg.sv ====
package lss_pkg;
  typedef logic [2:0] lss_addr_t;
  typedef enum logic [4:0] {
    RX_IDLE  = 5'h01,
    RX_START = 5'h02,
    RX_DATA  = 5'h04,
    RX_STOP  = 5'h08,
    RX_BRKW  = 5'h10
  } lss_rx_t;
  typedef enum logic [2:0] {
    HD_NONE  = 3'h1,
    HD_SYNC  = 3'h2,
    HD_IDENT = 3'h4
  } lss_hdr_t;
  typedef enum logic [2:0] {
    TX_IDLE  = 3'h1,
    TX_SHIFT = 3'h2,
    TX_BRK   = 3'h4
  } lss_tx_t;
endpackage : lss_pkg

// ==== lss_core.sv ====
// Design decisions made here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "lss_defs.svh"
// Behaviour
// [RQ1] Header error on bad sync, timeout, overrun
// [RQ2] Header error interrupts; cleared after sync state
// [RQ3] Noise flag only outside slave mode
// [RQ4] Framing error real only, never on break
// [RQ5] Parity error on identifier, interrupt enable
// [RQ6] Parity check enable switches identifier check
// [RQ7] Mute request set/cleared, hardware clears on wake
// [RQ8] Mute locked while receive full in slave
// [RQ9] Send break; set-then-clear sends one break (code: a set while idle starts one break and the clear queues one more)
// [RQ10] Divider update immediate or at next character
// [RQ11] Delayed update reloads previous nominal value
// [RQ12] Two-bit mode decode: off, master, slave
// [RQ13] Master break is 13 low bits
// [RQ14] Slave divider slots, 11-bit break, LIN wake
// [RQ15] Slave mode inhibits break transmission
// [RQ16] Auto-sync enable, slave mode only
// [RQ17] Header method selects detection and wake event
// [RQ18] Header interrupt when enabled and flag set
// [RQ19] Header flag set, cleared by status then control
// [RQ20] Identifier method needs break, sync, identifier
// [RQ21] Sync state set on break, hw/sw clear
// [RQ22] Mute slave discards bits until 11 dominant
// [RQ23] Baud is clock over 16 times 8.4 divider
// [RQ24] Header timeout only beyond 57 bit periods
module lss_core #(
  parameter int unsigned BRK_BITS     = `LSS_BRK_BITS,
  parameter int unsigned HDR_MAX_BITS = `LSS_HDR_MAX_BITS
) (
  // Clock and reset
  input  wire logic               mclk_in,
  input  wire logic               rst_b_in,
  // Register port
  input  wire lss_pkg::lss_addr_t addr_in,
  input  wire logic [7:0]         wdata_in,
  input  wire logic               wr_in,
  input  wire logic               rd_in,
  output logic [7:0]              rdata_out,
  // LIN line
  input  wire logic               receive_input_in,
  output logic                    tx_out,
  // Interrupt
  output logic                    irq_out
);
  import lss_pkg::*;

  localparam logic [7:0] BRK_TICKS = 8'(BRK_BITS * `LSS_OVS - 1);
  localparam logic [9:0] HDR_TICKS = 10'(HDR_MAX_BITS * `LSS_OVS);
  localparam logic [3:0] MBRK_N    = 4'(`LSS_MBRK_BITS);
  localparam logic [3:0] PBRK_N    = 4'(`LSS_PBRK_BITS);

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_b_in);

  logic [7:0]  cr1_ff, cr2_ff, cr3_ff, data_ff, nom_mant_ff, tx_buf_ff;
  logic [3:0]  nom_frac_ff, s_cnt_ff, tx_tk_ff, tx_bits_ff;
  logic [11:0] baud_divisor_ff;
  logic [12:0] acc_ff, acc_sum;
  logic [2:0]  bit_cnt_ff, smp_ff, fe_cnt_ff;
  logic [7:0]  sh_ff, low_cnt_ff;
  logic [9:0]  hdr_t_ff;
  logic [14:0] meas_ff, meas_nxt;
  logic [13:0] tx_sh_ff;
  logic        tick_ff, rx_prev_ff, noise_acc_ff, low_done_ff, sync_blk_ff;
  logic        rfull_ff, herr_ff, fe_ff, pe_ff, noise_ff, seq_ff;
  logic        dum_ff, hdr_det_ff, sync_st_ff, mute_ff, brk_pend_ff;
  logic        tdre_ff, tc_ff, tx_ff, irq_ff;
  logic [7:0]  rdata_ff;
  lss_rx_t     rx_st_ff;
  lss_hdr_t    hdr_ph_ff;
  lss_tx_t     tx_st_ff;

  logic wr_data, wr_baud, wr_ext, wr_cr1, wr_cr2, wr_cr3;
  logic rd_st, rd_data, rd_cr3, clr_data, clr_cr3;
  logic lin_en, slave_mode, master_mode, hdm, asu_en, rx, fall;
  logic maj, noisy, bit_end, char_done, all_zero, frame_err;
  logic break_ev, sync_abort, sync_done, sync_ok, id_done, hdr_tmo, par_bad;
  logic xfer, ovr, herr_set, fe_set, pe_set, noise_set, hdf_set, wake;
  logic asu_load, dly_load, brk_req;
  logic [3:0] brk_n;

  assign wr_data  = wr_in && addr_in == `LSS_A_DATA;
  assign wr_baud  = wr_in && addr_in == `LSS_A_BAUD;
  assign wr_ext   = wr_in && addr_in == `LSS_A_EXT;
  assign wr_cr1   = wr_in && addr_in == `LSS_A_CR1;
  assign wr_cr2   = wr_in && addr_in == `LSS_A_CR2;
  assign wr_cr3   = wr_in && addr_in == `LSS_A_CR3;
  assign rd_st    = rd_in && addr_in == `LSS_A_STATUS;
  assign rd_data  = rd_in && addr_in == `LSS_A_DATA;
  assign rd_cr3   = rd_in && addr_in == `LSS_A_CR3;
  assign clr_data = rd_data && seq_ff;
  assign clr_cr3  = rd_cr3 && seq_ff;

  // [RQ12] Mode decode
  assign lin_en      = cr3_ff[`LSS_B_LIN_EN];
  assign slave_mode  = lin_en && cr3_ff[`LSS_B_SLAVE];
  assign master_mode = lin_en && !cr3_ff[`LSS_B_SLAVE];
  assign hdm         = cr3_ff[`LSS_B_HDR_MTH];
  // [RQ16] Auto-sync slave only
  assign asu_en      = slave_mode && cr3_ff[`LSS_B_ASYNC];
  assign rx          = receive_input_in;
  assign fall        = rx_prev_ff && !rx;

  // [RQ23] Fractional tick at 16x baud
  assign acc_sum = acc_ff + 13'h0010;
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      acc_ff  <= 13'h0000;
      tick_ff <= 1'b0;
    end else if (baud_divisor_ff[11:4] == 8'h00) begin
      acc_ff  <= 13'h0000;
      tick_ff <= 1'b0;
    end else if (acc_sum >= {1'b0, baud_divisor_ff}) begin
      acc_ff  <= acc_sum - {1'b0, baud_divisor_ff};
      tick_ff <= 1'b1;
    end else begin
      acc_ff  <= acc_sum;
      tick_ff <= 1'b0;
    end
  end

  // Majority of samples 7, 8 and 9
  assign maj       = (smp_ff[0] & smp_ff[1]) | (smp_ff[0] & smp_ff[2]) | (smp_ff[1] & smp_ff[2]);
  assign noisy     = !(&smp_ff) && (|smp_ff);
  assign bit_end   = tick_ff && s_cnt_ff == 4'hf;
  assign char_done = rx_st_ff == RX_STOP && bit_end;
  assign all_zero  = sh_ff == 8'h00 && !maj;
  // [RQ4] Dominant stop with a recessive bit
  assign frame_err = !maj && !all_zero;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rx_st_ff     <= RX_IDLE;
      s_cnt_ff     <= 4'h0;
      bit_cnt_ff   <= 3'h0;
      smp_ff       <= 3'h7;
      sh_ff        <= 8'h00;
      noise_acc_ff <= 1'b0;
      rx_prev_ff   <= 1'b1;
    end else begin
      rx_prev_ff <= rx;
      if (tick_ff && s_cnt_ff >= 4'h7 && s_cnt_ff <= 4'h9) begin
        smp_ff <= {smp_ff[1:0], rx};
      end
      if (rx_st_ff == RX_IDLE) begin
        s_cnt_ff <= 4'h0;
      end else if (tick_ff) begin
        s_cnt_ff <= s_cnt_ff + 4'h1;
      end
      if (bit_end && noisy) begin
        noise_acc_ff <= 1'b1;
      end
      if (break_ev || sync_abort) begin
        rx_st_ff <= RX_BRKW;
      end else begin
        unique case (rx_st_ff)
          RX_IDLE: begin
            noise_acc_ff <= 1'b0;
            if (!rx) begin
              rx_st_ff <= RX_START;
            end
          end
          RX_START: begin
            bit_cnt_ff <= 3'h0;
            if (bit_end) begin
              rx_st_ff <= maj ? RX_IDLE : RX_DATA;
            end
          end
          RX_DATA: begin
            if (bit_end) begin
              sh_ff      <= {maj, sh_ff[7:1]};
              bit_cnt_ff <= bit_cnt_ff + 3'h1;
              if (bit_cnt_ff == 3'h7) begin
                rx_st_ff <= RX_STOP;
              end
            end
          end
          RX_STOP: begin
            if (bit_end) begin
              rx_st_ff <= maj ? RX_IDLE : RX_BRKW;
            end
          end
          RX_BRKW: begin
            if (rx) begin
              rx_st_ff <= RX_IDLE;
            end
          end
        endcase
      end
    end
  end

  // [RQ14] Break is 11 dominant bits
  assign break_ev = slave_mode && tick_ff && !rx && low_cnt_ff == BRK_TICKS && !low_done_ff;
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      low_cnt_ff  <= 8'h00;
      low_done_ff <= 1'b0;
    end else if (rx) begin
      low_cnt_ff  <= 8'h00;
      low_done_ff <= 1'b0;
    end else if (tick_ff) begin
      if (low_cnt_ff != 8'hff) begin
        low_cnt_ff <= low_cnt_ff + 8'h01;
      end
      if (break_ev) begin
        low_done_ff <= 1'b1;
      end
    end
  end

  // Header sequence
  assign sync_abort = wr_cr3 && !wdata_in[`LSS_B_SYNC_ST] && sync_st_ff && !break_ev;
  assign sync_done  = hdr_ph_ff == HD_SYNC && char_done && !sync_blk_ff;
  assign sync_ok    = sync_done && maj && sh_ff == `LSS_SYNC_BYTE;
  assign id_done    = hdr_ph_ff == HD_IDENT && char_done;
  // [RQ24] Time out only past the limit
  assign hdr_tmo    = hdr_ph_ff != HD_NONE && !sync_blk_ff && tick_ff && hdr_t_ff == HDR_TICKS;
  assign par_bad    = (sh_ff[6] != ^{sh_ff[0], sh_ff[1], sh_ff[2], sh_ff[4]}) ||
                      (sh_ff[7] != ~^{sh_ff[1], sh_ff[3], sh_ff[4], sh_ff[5]});

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hdr_ph_ff   <= HD_NONE;
      hdr_t_ff    <= 10'h000;
      sync_blk_ff <= 1'b0;
    end else if (break_ev) begin
      hdr_ph_ff   <= HD_SYNC;
      hdr_t_ff    <= {2'b00, BRK_TICKS} + 10'h001;
      sync_blk_ff <= 1'b0;
    end else if (sync_abort || hdr_tmo) begin
      hdr_ph_ff   <= HD_NONE;
      sync_blk_ff <= 1'b0;
    end else begin
      if (tick_ff && !sync_blk_ff) begin
        hdr_t_ff <= hdr_t_ff + 10'h001;
      end
      unique case (hdr_ph_ff)
        HD_NONE: begin
        end
        HD_SYNC: begin
          // [RQ20] Sync then identifier
          if (sync_done) begin
            if (sync_ok) begin
              hdr_ph_ff <= HD_IDENT;
            end else begin
              sync_blk_ff <= 1'b1;
            end
          end
        end
        HD_IDENT: begin
          if (id_done) begin
            hdr_ph_ff <= HD_NONE;
          end
        end
      endcase
    end
  end

  // [RQ22] Muted bits discarded outside header
  assign xfer      = char_done && maj && !mute_ff && hdr_ph_ff != HD_SYNC && !rfull_ff;
  assign ovr       = char_done && maj && !mute_ff && hdr_ph_ff != HD_SYNC && rfull_ff;
  // [RQ1] Three header error causes
  assign herr_set  = ovr || hdr_tmo || (sync_done && !sync_ok);
  assign fe_set    = char_done && frame_err && !mute_ff && hdr_ph_ff != HD_SYNC;
  // [RQ6] Identifier parity check enable
  assign pe_set    = id_done && maj && slave_mode && cr1_ff[`LSS_B_PAR_CHK] && par_bad;
  // [RQ3] No noise flag in slave
  assign noise_set = char_done && !slave_mode && (noise_acc_ff || noisy);
  // [RQ17] Method selects header event
  assign hdf_set   = (break_ev && !hdm) || (id_done && hdm && maj);
  assign wake      = mute_ff && slave_mode && hdf_set;

  // Status flags; a set beats a clear
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rfull_ff <= 1'b0;
      herr_ff  <= 1'b0;
      fe_ff    <= 1'b0;
      pe_ff    <= 1'b0;
      noise_ff <= 1'b0;
      seq_ff   <= 1'b0;
      data_ff  <= 8'h00;
    end else begin
      if (xfer) begin
        data_ff <= sh_ff;
      end
      rfull_ff <= xfer || (rfull_ff && !clr_data);
      // [RQ2] Not clearable while sync state held
      herr_ff  <= herr_set || (herr_ff && !(clr_data && !sync_st_ff));
      fe_ff    <= fe_set || (fe_ff && !clr_data);
      // [RQ5] Parity flag and clear
      pe_ff    <= pe_set || (pe_ff && !clr_data);
      noise_ff <= noise_set || (noise_ff && !clr_data);
      if (rd_st) begin
        seq_ff <= 1'b1;
      end else if (rd_data || rd_cr3) begin
        seq_ff <= 1'b0;
      end
    end
  end

  // Auto-sync: five falling edges span eight bits
  assign meas_nxt = meas_ff + 15'h0001;
  assign asu_load = asu_en && hdr_ph_ff == HD_SYNC && fall && fe_cnt_ff == 3'h4;
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      fe_cnt_ff <= 3'h0;
      meas_ff   <= 15'h0000;
    end else if (hdr_ph_ff != HD_SYNC || !asu_en) begin
      fe_cnt_ff <= 3'h0;
      meas_ff   <= 15'h0000;
    end else begin
      if (fall && fe_cnt_ff != 3'h5) begin
        fe_cnt_ff <= fe_cnt_ff + 3'h1;
      end
      if (fe_cnt_ff != 3'h0 && meas_ff != 15'h7fff) begin
        meas_ff <= meas_nxt;
      end
    end
  end

  // Divider; measurement wins a coincident write
  assign dly_load = slave_mode && dum_ff && xfer;
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      nom_mant_ff <= 8'h00;
      nom_frac_ff <= 4'h0;
      baud_divisor_ff     <= 12'h000;
    end else begin
      if (wr_baud) begin
        nom_mant_ff <= wdata_in;
      end
      if (wr_ext) begin
        nom_frac_ff <= wdata_in[3:0];
      end
      // [RQ10] Immediate or delayed update
      if (asu_load) begin
        baud_divisor_ff <= meas_nxt[14:3];
      end else if (wr_baud && !(slave_mode && dum_ff)) begin
        baud_divisor_ff <= {wdata_in, nom_frac_ff};
      end else if (dly_load) begin
        // [RQ11] Old nominal when not rewritten
        baud_divisor_ff <= {nom_mant_ff, nom_frac_ff};
      end
    end
  end

  // Control registers
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cr1_ff      <= `LSS_CR_RST;
      cr2_ff      <= `LSS_CR_RST;
      cr3_ff      <= `LSS_CR_RST;
      mute_ff     <= 1'b0;
      dum_ff      <= 1'b0;
      hdr_det_ff  <= 1'b0;
      sync_st_ff  <= 1'b0;
      brk_pend_ff <= 1'b0;
    end else begin
      if (wr_cr1) begin
        cr1_ff <= {wdata_in[7:2], 1'b0, wdata_in[0]};
      end
      if (wr_cr2) begin
        cr2_ff <= wdata_in;
      end
      if (wr_cr3) begin
        cr3_ff <= {1'b0, wdata_in[6:2], 2'b00};
      end
      // [RQ7] Hardware clears mute on wake
      if (wake) begin
        mute_ff <= 1'b0;
      end else if (wr_cr2 && !(slave_mode && rfull_ff)) begin
        // [RQ8] Write lock while receive full
        mute_ff <= wdata_in[`LSS_B_MUTE];
      end
      if (slave_mode && xfer) begin
        dum_ff <= 1'b0;
      end else if (wr_cr3) begin
        dum_ff <= wdata_in[`LSS_B_DIV_UPD];
      end
      // [RQ19] Header flag set and clear
      hdr_det_ff <= (slave_mode && hdf_set) || (hdr_det_ff && !clr_cr3);
      // [RQ21] Sync state set and clears
      if (break_ev) begin
        sync_st_ff <= 1'b1;
      end else if (sync_ok || hdr_tmo || sync_abort) begin
        sync_st_ff <= 1'b0;
      end
      // [RQ9] Falling send break queues one
      if (wr_cr2 && cr2_ff[`LSS_B_BRK] && !wdata_in[`LSS_B_BRK]) begin
        brk_pend_ff <= 1'b1;
      end else if (tx_st_ff == TX_IDLE && brk_req) begin
        brk_pend_ff <= 1'b0;
      end
    end
  end

  // [RQ15] No break in slave mode
  assign brk_req = !slave_mode && (cr2_ff[`LSS_B_BRK] || brk_pend_ff);
  // [RQ13] Master break length
  assign brk_n   = master_mode ? MBRK_N : PBRK_N;

  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      tx_st_ff   <= TX_IDLE;
      tx_sh_ff   <= 14'h3fff;
      tx_bits_ff <= 4'h0;
      tx_tk_ff   <= 4'h0;
      tx_buf_ff  <= 8'h00;
      tdre_ff    <= 1'b1;
      tc_ff      <= 1'b1;
      tx_ff      <= 1'b1;
    end else begin
      if (wr_data) begin
        tx_buf_ff <= wdata_in;
        tdre_ff   <= 1'b0;
        tc_ff     <= 1'b0;
      end
      unique case (tx_st_ff)
        TX_IDLE: begin
          tx_tk_ff <= 4'h0;
          if (brk_req) begin
            tx_sh_ff   <= 14'h0001 << brk_n;
            tx_bits_ff <= brk_n + 4'h1;
            tx_ff      <= 1'b0;
            tx_st_ff   <= TX_BRK;
            tc_ff      <= 1'b0;
          end else if (!tdre_ff) begin
            tx_sh_ff   <= {5'h01, tx_buf_ff, 1'b0};
            tx_bits_ff <= 4'ha;
            tx_ff      <= 1'b0;
            tx_st_ff   <= TX_SHIFT;
            tdre_ff    <= wr_data ? 1'b0 : 1'b1;
          end
        end
        TX_SHIFT, TX_BRK: begin
          if (tick_ff) begin
            tx_tk_ff <= tx_tk_ff + 4'h1;
          end
          if (tick_ff && tx_tk_ff == 4'hf) begin
            if (tx_bits_ff == 4'h1) begin
              tx_ff    <= 1'b1;
              tx_st_ff <= TX_IDLE;
              tc_ff    <= tdre_ff && !wr_data;
            end else begin
              tx_sh_ff   <= tx_sh_ff >> 1;
              tx_ff      <= tx_sh_ff[1];
              tx_bits_ff <= tx_bits_ff - 4'h1;
            end
          end
        end
      endcase
    end
  end

  // Interrupt and read data
  always_ff @(posedge mclk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_ff   <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      // [RQ18] Header interrupt gating
      irq_ff <= (cr2_ff[`LSS_B_RX_IRQ] && (rfull_ff || herr_ff)) ||
                (cr1_ff[`LSS_B_PAR_IRQ] && pe_ff) ||
                (slave_mode && cr3_ff[`LSS_B_HDR_IRQ] && hdr_det_ff);
      rdata_ff <= 8'h00;
      if (rd_in) begin
        unique case (addr_in)
          `LSS_A_STATUS: rdata_ff <= {tdre_ff, tc_ff, rfull_ff, 1'b0,
                                      herr_ff, noise_ff, fe_ff, pe_ff};
          `LSS_A_DATA:   rdata_ff <= data_ff;
          `LSS_A_BAUD:   rdata_ff <= nom_mant_ff;
          `LSS_A_EXT:    rdata_ff <= {4'h0, nom_frac_ff};
          `LSS_A_CR1:    rdata_ff <= cr1_ff;
          `LSS_A_CR2:    rdata_ff <= {cr2_ff[7:2], mute_ff, cr2_ff[0]};
          `LSS_A_CR3:    rdata_ff <= {dum_ff, cr3_ff[6:2], hdr_det_ff, sync_st_ff};
          default:       rdata_ff <= 8'h00;
        endcase
      end
    end
  end

  assign rdata_out = rdata_ff;
  assign tx_out    = tx_ff;
  assign irq_out   = irq_ff;

  brk_sync_a: assert property (break_ev |=> sync_st_ff && hdr_ph_ff == HD_SYNC) // [RQ21]
    else $error("break did not enter sync state");
  brk_hdr_a: assert property (break_ev && !hdm |=> hdr_det_ff) // [RQ17]
    else $error("break method missed header flag");
  mute_lock_a: assert property (wr_cr2 && slave_mode && rfull_ff && !wake // [RQ8]
                                |=> $stable(mute_ff))
    else $error("mute changed while receive full");
  par_set_a: assert property (pe_set |=> pe_ff) // [RQ5]
    else $error("parity error not flagged");
  fe_brk_a: assert property (char_done && all_zero |=> !$rose(fe_ff)) // [RQ4]
    else $error("framing flag set on break");
  slv_brk_a: assert property (slave_mode && tx_st_ff == TX_IDLE |=> tx_st_ff != TX_BRK) // [RQ15]
    else $error("break sent in slave mode");
  div_now_a: assert property (wr_baud && !(slave_mode && dum_ff) && !asu_load
                              |=> baud_divisor_ff == {$past(wdata_in), $past(nom_frac_ff)}) // [RQ10]
    else $error("divider not loaded on write");
  hdr_len_a: assert property (hdr_tmo |-> hdr_t_ff == HDR_TICKS && herr_set) // [RQ24]
    else $error("header timeout at wrong length");
  hdr_irq_a: assert property (slave_mode && cr3_ff[`LSS_B_HDR_IRQ] && hdr_det_ff // [RQ18]
                              |=> irq_ff)
    else $error("header interrupt missing");
  herr_hold_a: assert property (herr_ff && sync_st_ff |=> herr_ff) // [RQ2]
    else $error("header error cleared in sync state");

  brk_c: cover property (break_ev);
  hdr_id_c: cover property (id_done && hdm && maj);
  asu_c: cover property (asu_load);
  txbrk_c: cover property (tx_st_ff == TX_IDLE ##1 tx_st_ff == TX_BRK);
endmodule : lss_core

// ==== lss_lin_master.sv ====
`timescale 1ns/1ps
// LIN master on the far side; the line idles recessive, driven high by this model
module lss_lin_master #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic clk_in,
  output logic      line_out
);
  initial line_out = 1'b1;
  task automatic hold(input logic v, input int nbits);
    line_out <= v;
    repeat (nbits * BIT_CLKS) @(posedge clk_in);
  endtask : hold
  task automatic send_break(input int nbits);
    hold(1'b0, nbits);
    hold(1'b1, 1);
  endtask : send_break
  task automatic send_byte(input logic [7:0] d, input logic stop);
    hold(1'b0, 1);
    for (int i = 0; i < 8; i++) begin
      hold(d[i], 1);
    end
    hold(stop, 1);
    hold(1'b1, 2);
  endtask : send_byte
endmodule : lss_lin_master

// ==== test_lin_slave_serial_mode.sv ====
`timescale 1ns/1ps
`include "lss_defs.svh"
module test_lin_slave_serial_mode;
  import lss_pkg::*;
  logic       mclk_in;
  logic       rst_b_in;
  lss_addr_t  addr_in;
  logic [7:0] wdata_in;
  logic       wr_in;
  logic       rd_in;
  logic [7:0] rdata_out;
  logic       rx_line;
  logic       tx_out;
  logic       irq_out;
  int         num_errors;
  int         n_compared;

  lss_core i_dut (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .receive_input_in(rx_line),
    .tx_out(tx_out), .irq_out(irq_out));
  lss_lin_master i_lin (.clk_in(mclk_in), .line_out(rx_line));

  always #2.5 mclk_in = ~mclk_in;

  task automatic print_verdict;
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s exp=%h seen=%h", what, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask : wr

  // Read data stand one cycle only, so sample just after that edge
  task automatic rdchk(input logic [2:0] a, input logic [7:0] exp, input string what);
    @(posedge mclk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    chk(what, rdata_out, exp);
  endtask : rdchk

  function automatic logic [7:0] pid(input logic [5:0] i);
    return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
  endfunction : pid

  task automatic hdr(input logic [7:0] id);
    i_lin.send_break(13);
    i_lin.send_byte(8'h55, 1'b1);
    i_lin.send_byte(id, 1'b1);
  endtask : hdr

  // Status then data, then status then control three
  task automatic clr(input logic [7:0] st, input logic [7:0] dr, input logic [7:0] c3);
    rdchk(`LSS_A_STATUS, st, "status");
    rdchk(`LSS_A_DATA, dr, "data");
    rdchk(`LSS_A_STATUS, st & 8'hc0, "status clr");
    rdchk(`LSS_A_CR3, c3, "cr3");
    rdchk(`LSS_A_CR3, c3 & 8'hfd, "cr3 clr");
  endtask : clr

  task automatic t_header;
    wr(`LSS_A_CR3, 8'h64);
    i_lin.send_break(13);
    chk("irq hdr", {7'h0, irq_out}, 8'h01);
    rdchk(`LSS_A_CR3, 8'h67, "cr3 brk");
    i_lin.send_byte(8'h55, 1'b1);
    rdchk(`LSS_A_CR3, 8'h66, "cr3 sync");
    i_lin.send_byte(pid(6'h12), 1'b1);
    clr(8'he0, pid(6'h12), 8'h66);
    chk("irq off", {7'h0, irq_out}, 8'h00);
    wr(`LSS_A_CR3, 8'h6c);
    i_lin.send_break(13);
    rdchk(`LSS_A_CR3, 8'h6d, "cr3 id brk");
    i_lin.send_byte(8'h55, 1'b1);
    i_lin.send_byte(pid(6'h05), 1'b1);
    clr(8'he0, pid(6'h05), 8'h6e);
  endtask : t_header

  task automatic t_parity;
    wr(`LSS_A_CR3, 8'h60);
    wr(`LSS_A_CR1, 8'h05);
    hdr(pid(6'h12) ^ 8'h40);
    chk("irq par", {7'h0, irq_out}, 8'h01);
    clr(8'he1, pid(6'h12) ^ 8'h40, 8'h62);
    wr(`LSS_A_CR1, 8'h01);
    hdr(pid(6'h12) ^ 8'h40);
    clr(8'he0, pid(6'h12) ^ 8'h40, 8'h62);
    i_lin.send_break(13);
    i_lin.send_byte(8'h55, 1'b1);
    i_lin.send_byte(8'h0f, 1'b0);
    // Bad stop keeps the old data and leaves receive full clear
    clr(8'hc2, 8'hd2, 8'h62);
  endtask : t_parity

  task automatic t_badsync;
    wr(`LSS_A_CR2, 8'h20);
    i_lin.send_break(13);
    i_lin.send_byte(8'h0f, 1'b1);
    chk("irq herr", {7'h0, irq_out}, 8'h01);
    rdchk(`LSS_A_STATUS, 8'hc8, "status herr");
    rdchk(`LSS_A_DATA, 8'hd2, "data blk");
    rdchk(`LSS_A_STATUS, 8'hc8, "herr held");
    rdchk(`LSS_A_CR3, 8'h63, "cr3 blk");
    wr(`LSS_A_CR3, 8'h60);
    clr(8'hc8, 8'hd2, 8'h60);
    // Header left without identifier runs past the limit
    i_lin.send_break(13);
    i_lin.send_byte(8'h55, 1'b1);
    repeat (640) @(posedge mclk_in);
    clr(8'hc8, 8'hd2, 8'h62);
    wr(`LSS_A_CR2, 8'h00);
  endtask : t_badsync

  task automatic t_mute;
    hdr(pid(6'h12));
    wr(`LSS_A_CR2, 8'h02);
    rdchk(`LSS_A_CR2, 8'h00, "mute lock");
    clr(8'he0, pid(6'h12), 8'h62);
    wr(`LSS_A_CR2, 8'h02);
    rdchk(`LSS_A_CR2, 8'h02, "mute set");
    i_lin.send_byte(8'h00, 1'b1);
    rdchk(`LSS_A_CR2, 8'h02, "mute 9 low");
    rdchk(`LSS_A_STATUS, 8'hc0, "mute drop");
    i_lin.send_break(13);
    rdchk(`LSS_A_CR2, 8'h00, "mute wake");
    i_lin.send_byte(8'h55, 1'b1);
    i_lin.send_byte(pid(6'h12), 1'b1);
    clr(8'he0, pid(6'h12), 8'h62);
  endtask : t_mute

  task automatic t_txbreak;
    int w;
    int n;
    w = 0;
    n = 0;
    wr(`LSS_A_CR3, 8'h40);
    wr(`LSS_A_CR2, 8'h01);
    wr(`LSS_A_CR2, 8'h00);
    while (tx_out !== 1'b0 && w < 100) begin
      @(posedge mclk_in);
      w++;
    end
    if (w == 100) begin
      num_errors++;
      print_verdict();
    end
    while (tx_out === 1'b0 && n < 400) begin
      @(posedge mclk_in);
      n++;
    end
    chk("break len", 8'(n), 8'(13 * 16));
    // Set then clear queues exactly one more break
    n = 0;
    repeat (600) begin
      @(posedge mclk_in);
      n += (tx_out === 1'b0) ? 1 : 0;
    end
    chk("queued brk", 8'(n), 8'(13 * 16));
    wr(`LSS_A_CR3, 8'h60);
    wr(`LSS_A_CR2, 8'h01);
    n = 0;
    repeat (300) begin
      @(posedge mclk_in);
      n += (tx_out === 1'b1) ? 0 : 1;
    end
    chk("slave brk", 8'(n), 8'h00);
  endtask : t_txbreak

  initial begin
    mclk_in = 1'b0;
    rst_b_in = 1'b0;
    addr_in = '0;
    wdata_in = 8'h00;
    wr_in = 1'b0;
    rd_in = 1'b0;
    num_errors = 0;
    n_compared = 0;
    repeat (6) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    rdchk(`LSS_A_STATUS, `LSS_STATUS_RST, "status rst");
    rdchk(`LSS_A_CR3, `LSS_CR_RST, "cr3 rst");
    rdchk(3'h7, 8'h00, "unmapped");
    // Divider of one gives one clock per sample, keeping frames short
    wr(`LSS_A_EXT, 8'h00);
    wr(`LSS_A_BAUD, 8'h01);
    t_header();
    t_parity();
    t_badsync();
    t_mute();
    t_txbreak();
    // Second reset in mid-run must drop the break request
    rst_b_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    rdchk(`LSS_A_CR2, `LSS_CR_RST, "cr2 rst");
    rdchk(`LSS_A_STATUS, `LSS_STATUS_RST, "status rst2");
    print_verdict();
  end
endmodule : test_lin_slave_serial_mode
